//--- hdl/acmp_pkg.sv
// Purpose: Shared constants and types for the comparator control block
// Assumes: 32-bit AHB-Lite data, one word per register
// Notes:   Register byte address is four times the register index
package acmp_pkg;
  // ----------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------
  localparam logic [15:0] IDX_AB_CONFIG  = 16'ha030;
  localparam logic [15:0] IDX_CD_CONFIG  = 16'ha031;
  localparam logic [15:0] IDX_LEVEL0     = 16'ha032;
  localparam logic [15:0] IDX_LEVEL1     = 16'ha033;
  localparam logic [15:0] IDX_LIVE       = 16'ha034;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'ha035;
  localparam logic [15:0] IDX_IRQ_MASK   = 16'ha038;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int          NUM_CHAN      = 4;
  localparam int          LEVEL_W       = 8;
  localparam int          CFG_W         = 4;
  localparam int          HI_NIBBLE_LSB = 4;
  localparam logic [7:0]  CONFIG_RESET  = 8'h00;
  localparam logic [7:0]  LEVEL_RESET   = 8'h00;
  localparam logic [3:0]  MASK_RESET    = 4'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ       = 250;
  localparam int SETTLE_US     = 20;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam int SETTLE_W      = 16;

  // Channel indices; pad A and D share one input
  localparam int CH_A = 0;
  localparam int CH_B = 1;
  localparam int CH_C = 2;
  localparam int CH_D = 3;

  // Per-channel control, top bit first as stored in a config nibble
  typedef struct packed {
    logic on;
    logic thresh_src;
    logic irq_on;
    logic invert;
  } chan_cfg_s;

  // Captured AHB address phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
  } ahb_phase_s;
endpackage

//--- hdl/analog_comparator_control.sv
// Purpose: Control and event logic for four analog comparators, AHB-Lite slave
// Assumes: Comparator outputs arrive asynchronously; one 250 MHz clock
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control
  import acmp_pkg::*;
#(
  parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 ce,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // Analog comparator cells
  input  wire logic [NUM_CHAN-1:0]  comp_raw,
  output logic [NUM_CHAN-1:0]       comp_power_on,
  output logic [NUM_CHAN-1:0]       comp_use_external,
  output logic [LEVEL_W-1:0]        internal_threshold_level0,
  output logic [LEVEL_W-1:0]        internal_threshold_level1,
  // Pad usage for P1.4 .. P1.7
  output logic [3:0]                pad_comparator_use,
  // Interrupt
  output logic                      irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]             ab_config;
  logic [7:0]             cd_config;
  logic [LEVEL_W-1:0]     level0;
  logic [LEVEL_W-1:0]     level1;
  logic [NUM_CHAN-1:0]    irq_status;
  logic [NUM_CHAN-1:0]    irq_mask;
  logic [NUM_CHAN-1:0]    sync_a;
  logic [NUM_CHAN-1:0]    sync_b;
  logic [NUM_CHAN-1:0]    prev_out;
  logic [NUM_CHAN-1:0]    settled;
  logic [NUM_CHAN-1:0]    live_out;
  logic [NUM_CHAN-1:0]    edge_event;
  logic [NUM_CHAN-1:0]    read_clear;
  chan_cfg_s              cfg [NUM_CHAN];
  ahb_phase_s             dphase;
  logic                   accept;
  logic [31:0]            next_rdata;

  // ----------------------------------------
  // Register map, index then name (byte address = index * 4)
  // ----------------------------------------
  // a030 ab_config  : A nibble over B nibble; on, src, irq_on, invert
  // a031 cd_config  : C nibble over D nibble, same layout
  // a032 level0     : internal threshold code 0
  // a033 level1     : internal threshold code 1
  // a034 live       : settled flags over live outputs, read only
  // a035 irq_status : sticky edge flags, cleared by the read that returns them
  // a038 irq_mask   : gates the irq output, same layout as the status
  // Unmapped indices read zero and drop writes; the bus always answers OKAY
  //
  // Edge to flag takes three edges: two synchroniser stages, then the flag.
  // The irq flop uses the next flag value, so it moves on that same edge.
  // With ce low every flop holds and hreadyout stalls the master.

  // Register index from a byte address; upper bits must be zero
  function automatic logic [16:0] reg_index(input logic [31:0] addr);
    reg_index = {(addr[31:18] != 14'h0000), addr[17:2]};
  endfunction

  // Data-phase write strobe for one register index
  function automatic logic wr_hit(input ahb_phase_s ph, input logic [15:0] idx);
    wr_hit = ph.valid && (ph.index == idx);
  endfunction

  // ----------------------------------------
  // Channel view of the configuration registers
  // ----------------------------------------
  // High nibble holds the first channel of a pair
  always_comb begin
    cfg[CH_A] = chan_cfg_s'(ab_config[7:HI_NIBBLE_LSB]);
    cfg[CH_B] = chan_cfg_s'(ab_config[CFG_W-1:0]);
    cfg[CH_C] = chan_cfg_s'(cd_config[7:HI_NIBBLE_LSB]);
    cfg[CH_D] = chan_cfg_s'(cd_config[CFG_W-1:0]);
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // Stall the bus while frozen so no transfer is lost
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign accept    = ce && hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);

  // Address phase capture; hsize ignored, only words are mapped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase <= '0;
    end else if (ce) begin
      dphase.valid <= accept && hwrite && (haddr[31:18] == 14'h0000);
      dphase.write <= hwrite;
      dphase.index <= haddr[17:2];
    end
  end

  // Read data prepared in the address phase, held in a flop
  // Loading early keeps the data phase free of wait states
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_index(haddr))
      {1'b0, IDX_AB_CONFIG}:  next_rdata[7:0] = ab_config;
      {1'b0, IDX_CD_CONFIG}:  next_rdata[7:0] = cd_config;
      {1'b0, IDX_LEVEL0}:     next_rdata[7:0] = level0;
      {1'b0, IDX_LEVEL1}:     next_rdata[7:0] = level1;
      {1'b0, IDX_LIVE}:       next_rdata[7:0] = {settled, live_out};
      {1'b0, IDX_IRQ_STATUS}: next_rdata[3:0] = irq_status;
      {1'b0, IDX_IRQ_MASK}:   next_rdata[3:0] = irq_mask;
      default:                next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data register, loaded at the address-phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && accept && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // Status read clears whatever it returned
  assign read_clear = (accept && !hwrite && reg_index(haddr) == {1'b0, IDX_IRQ_STATUS})
                      ? irq_status : '0;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Channel A has no external option, so its select bit is held at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ab_config <= CONFIG_RESET;
      cd_config <= CONFIG_RESET;
    end else if (ce && dphase.valid) begin
      if (wr_hit(dphase, IDX_AB_CONFIG)) begin
        ab_config    <= hwdata[7:0];
        ab_config[6] <= 1'b0;
      end
      if (wr_hit(dphase, IDX_CD_CONFIG)) begin
        cd_config <= hwdata[7:0];
      end
    end
  end

  // Two internal threshold codes, 256 steps each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level0 <= LEVEL_RESET;
      level1 <= LEVEL_RESET;
    end else if (ce && dphase.valid) begin
      if (wr_hit(dphase, IDX_LEVEL0)) begin
        level0 <= hwdata[LEVEL_W-1:0];
      end
      if (wr_hit(dphase, IDX_LEVEL1)) begin
        level1 <= hwdata[LEVEL_W-1:0];
      end
    end
  end

  // Interrupt mask, same layout as the status register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= MASK_RESET;
    end else if (ce && wr_hit(dphase, IDX_IRQ_MASK)) begin
      irq_mask <= hwdata[NUM_CHAN-1:0];
    end
  end

  // ----------------------------------------
  // Analog side controls
  // ----------------------------------------
  // A and D share a pad; they compare against separate codes
  assign internal_threshold_level0 = level0;
  assign internal_threshold_level1 = level1;

  // Power and threshold source per channel, straight from the config nibbles
  generate
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_ctrl
      assign comp_power_on[i]     = cfg[i].on;
      assign comp_use_external[i] = (i != CH_A) && cfg[i].thresh_src;
    end
  endgenerate

  // P1.4 A and D, P1.5 B, P1.6 C, P1.7 external threshold
  assign pad_comparator_use[0] = cfg[CH_A].on || cfg[CH_D].on;
  assign pad_comparator_use[1] = cfg[CH_B].on;
  assign pad_comparator_use[2] = cfg[CH_C].on;
  assign pad_comparator_use[3] = |(comp_power_on & comp_use_external);

  // ----------------------------------------
  // Output synchroniser, polarity and edge detect
  // ----------------------------------------
  // First stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (ce) begin
      sync_a <= comp_raw;
      sync_b <= sync_a;
    end
  end

  // Edges are taken before inversion so flipping polarity makes no event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_out <= '0;
    end else if (ce) begin
      prev_out <= sync_b;
    end
  end

  // One settle counter and event gate per channel
  generate
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
      logic [SETTLE_W-1:0] settle_cnt;

      assign live_out[i] = sync_b[i] ^ cfg[i].invert;
      // Both directions count; disabled or unsettled channels are quiet
      assign edge_event[i] = (sync_b[i] != prev_out[i]) && cfg[i].irq_on
                             && cfg[i].on && settled[i];

      // Bias settling time after power on; unreliable output ignored
      // Limitation: the counter width caps SETTLE_COUNT at 65536
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          settle_cnt <= '0;
          settled[i] <= 1'b0;
        end else if (ce) begin
          if (!cfg[i].on) begin
            settle_cnt <= '0;
            settled[i] <= 1'b0;
          end else if (settle_cnt >= SETTLE_W'(SETTLE_COUNT - 1)) begin
            settled[i] <= 1'b1;
          end else begin
            settle_cnt <= settle_cnt + 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Interrupt status and output
  // ----------------------------------------
  // A new edge wins over a read clear in the same cycle
  // so an event is never lost to a racing status read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
    end else if (ce) begin
      irq_status <= (irq_status & ~read_clear) | edge_event;
    end
  end

  // Level output while any unmasked flag is pending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |((irq_status & ~read_clear | edge_event) & irq_mask);
    end
  end

  // ----------------------------------------
  // Unused inputs
  // ----------------------------------------
  // Transfer size is not checked; every access is treated as a word
  logic unused_size;
  assign unused_size = ^{hsize, dphase.write};

endmodule
`default_nettype wire

//--- tb/acmp_cells.sv
// Purpose: Behavioural analog comparator cells and pads
// Assumes: Pad and threshold voltages given as 8-bit codes
// Notes:   A powered-off cell drives a flat low output
`timescale 1ns/1ps
`default_nettype none
module acmp_cells (
  // Controls from the block
  input  wire logic [3:0]  on,
  input  wire logic [3:0]  ext,
  input  wire logic [7:0]  th0,
  input  wire logic [7:0]  th1,
  // Pads P1.4 .. P1.7, one byte each
  input  wire logic [31:0] pads,
  // Raw outputs
  output logic [3:0]       raw
);
  // A and D share pad P1.4; B and C compare against the code or P1.7
  always_comb begin
    raw[0] = on[0] && (pads[7:0] > th0);
    raw[1] = on[1] && (pads[15:8] > (ext[1] ? pads[31:24] : th0));
    raw[2] = on[2] && (pads[23:16] > (ext[2] ? pads[31:24] : th1));
    raw[3] = on[3] && (pads[7:0] > (ext[3] ? pads[31:24] : th1));
  end
endmodule
`default_nettype wire

//--- tb/acmp_checker.sv
// Purpose: Port-level checks for the comparator block
// Assumes: One clock domain, hresetn async low
// Notes:   Bound into every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module acmp_checker #(
  parameter int SETTLE_COUNT = 8
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       ce,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic [3:0] comp_raw,
  input wire logic [3:0] comp_power_on,
  input wire logic [3:0] comp_use_external,
  input wire logic [3:0] pad_comparator_use,
  input wire logic       irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Accepted requests, seen in their address phase
  logic take;
  logic wtake;
  assign take  = hsel && htrans[1] && hready;
  assign wtake = take && hwrite;
  a_okay_resp: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  a_ready_ce: assert property (hreadyout == ce) else $error("hreadyout not ce");
  a_a_no_ext: assert property (comp_use_external[0] == 1'b0)
    else $error("channel A uses external threshold");
  a_pad_shared: assert property (
    pad_comparator_use[0] == (comp_power_on[0] | comp_power_on[3]))
    else $error("P1.4 use wrong");
  a_pad_bc: assert property (pad_comparator_use[2:1] == comp_power_on[2:1])
    else $error("P1.5 or P1.6 use wrong");
  a_pad_ext: assert property (
    pad_comparator_use[3] == |(comp_power_on & comp_use_external))
    else $error("P1.7 use wrong");
  // Three edges of latency: two sync flops, then the edge detector
  // A release of ce lets a change seen while frozen through late
  a_irq_cause: assert property ($rose(irq) |->
    ($past(comp_raw, 3) != $past(comp_raw, 4)) || $past(wtake, 2) || $past(wtake, 3)
    || !$past(ce, 4))
    else $error("irq rose without cause");
  // A mask write lands one edge after its address phase, irq one later
  a_irq_sticky: assert property ($fell(irq) |-> $past(take) || $past(wtake, 3))
    else $error("irq fell without access");
  c_irq_up: cover property ($rose(irq));
  c_irq_down: cover property ($fell(irq));
  c_ext_pad: cover property (pad_comparator_use[3]);
endmodule
bind analog_comparator_control acmp_checker #(.SETTLE_COUNT(SETTLE_COUNT)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .comp_raw(comp_raw), .comp_power_on(comp_power_on), .comp_use_external(comp_use_external),
  .pad_comparator_use(pad_comparator_use), .irq(irq));
`default_nettype wire

//--- tb/analog_comparator_control_tb.sv
// Purpose: Self-checking bench for the comparator block
// Assumes: Zero-wait AHB-Lite slave, settle count shortened to 8
// Notes:   Random configs and pads from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control_tb;
  import acmp_pkg::*;
  logic        hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, pads = 0, q;
  logic [3:0]  raw, pwr, ext, pad_use;
  logic [7:0]  th0, th1, lv0, lv1, ab, cd;
  logic [15:0] ri [6] = '{IDX_AB_CONFIG, IDX_CD_CONFIG, IDX_LEVEL0, IDX_LEVEL1,
                          IDX_IRQ_MASK, IDX_IRQ_STATUS};
  int          bad_count = 0, check_count = 0;
  always #2 hclk = ~hclk;
  analog_comparator_control #(.SETTLE_COUNT(8)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .comp_raw(raw), .comp_power_on(pwr), .comp_use_external(ext),
    .internal_threshold_level0(th0), .internal_threshold_level1(th1),
    .pad_comparator_use(pad_use), .irq(irq));
  acmp_cells u_cells (.on(pwr), .ext(ext), .th0(th0), .th1(th1), .pads(pads), .raw(raw));
  task end_of_test;
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One single transfer; bounded waits for hready in both phases
  task xfer(input logic w, input logic [15:0] i, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1;
    haddr <= {14'h0, i, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    q = hrdata;
    if (n >= 50) begin bad_count++; end_of_test; end
  endtask
  task rdc(input logic [15:0] i, input logic [31:0] e);
    xfer(0, i, 0);
    chk(q, e);
  endtask
  // Config write, then the settling wait software owes after enabling
  task cfg(input logic [7:0] a, input logic [7:0] c);
    ab = a & 8'hbf;
    cd = c;
    xfer(1, IDX_AB_CONFIG, {24'h0, a});
    xfer(1, IDX_CD_CONFIG, {24'h0, c});
    repeat (12) @(posedge hclk);
  endtask
  // Expected live byte: settled flags over polarity-adjusted outputs
  function logic [7:0] live();
    logic [3:0] on, inv, r;
    on = {cd[3], cd[7], ab[3], ab[7]};
    inv = {cd[0], cd[4], ab[0], ab[4]};
    r[0] = pads[7:0] > lv0;
    r[1] = pads[15:8] > (ab[2] ? pads[31:24] : lv0);
    r[2] = pads[23:16] > (cd[6] ? pads[31:24] : lv1);
    r[3] = pads[7:0] > (cd[2] ? pads[31:24] : lv1);
    return {on, (r & on) ^ inv};
  endfunction
  initial begin
    q = $urandom(25609);
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    foreach (ri[k]) rdc(ri[k], 0);
    chk({pwr, ext, pad_use, irq}, 0);
    xfer(1, 16'ha039, 32'hff);
    rdc(16'ha039, 0);
    // Pads are analog-only inputs here, drivers left to the cells
    repeat (6) begin
      lv0 = 8'($urandom);
      lv1 = 8'($urandom);
      pads <= $urandom;
      xfer(1, IDX_LEVEL0, {24'h0, lv0});
      xfer(1, IDX_LEVEL1, {24'h0, lv1});
      cfg(8'($urandom), 8'($urandom));
      rdc(IDX_LEVEL0, lv0);
      rdc(IDX_LEVEL1, lv1);
      rdc(IDX_AB_CONFIG, ab);
      rdc(IDX_CD_CONFIG, cd);
      chk(pwr, {cd[3], cd[7], ab[3], ab[7]});
      chk(ext, {cd[2], cd[6], ab[2], 1'b0});
      rdc(IDX_LIVE, live());
    end
    pads <= 0;
    lv0 = 8'h80;
    xfer(1, IDX_LEVEL0, 32'h80);
    cfg(8'ha0, 8'h00);
    xfer(0, IDX_IRQ_STATUS, 0);
    xfer(1, IDX_IRQ_MASK, 32'h1);
    // Rising then falling output on channel A
    for (int k = 0; k < 2; k++) begin
      pads[7:0] <= k ? 8'h10 : 8'hc0;
      repeat (6) @(posedge hclk);
      chk(irq, 1);
      rdc(IDX_IRQ_STATUS, 1);
      chk(irq, 0);
      rdc(IDX_IRQ_STATUS, 0);
    end
    xfer(1, IDX_IRQ_MASK, 0);
    pads[7:0] <= 8'hc0;
    repeat (6) @(posedge hclk);
    chk(irq, 0);
    xfer(1, IDX_IRQ_MASK, 32'h1);
    repeat (2) @(posedge hclk);
    chk(irq, 1);
    rdc(IDX_IRQ_STATUS, 1);
    // Frozen by ce: no bus answer and no edge until released
    ce <= 0;
    pads[7:0] <= 8'h10;
    repeat (6) @(posedge hclk);
    chk({hreadyout, irq}, 0);
    ce <= 1;
    repeat (6) @(posedge hclk);
    chk(irq, 1);
    rdc(IDX_IRQ_STATUS, 1);
    cfg(8'h20, 8'h00);
    rdc(IDX_IRQ_STATUS, 0);
    end_of_test;
  end
endmodule
`default_nettype wire
